// [logic/upsr_top.sv]
// pin swap and downstream port remap configuration with an AXI4-Lite slave
// assumes core PHY signals are on i_clock and pin inputs are asynchronous
`timescale 1ns/1ps
`include "upsr_regs.svh"

// Behaviour
// [RULE_01] swap bit 0: D+ drives and senses DP pin, D- on DM pin
// [RULE_02] swap bit 1: D+ goes to DM pin, D- to DP pin
// [RULE_03] swap bits 4..1 steer downstream ports 4..1; bits 7..5 do nothing
// [RULE_04] swap bit 0 exchanges the upstream port's D+ and D- pins
// [RULE_05] physical-to-logical mapping applies only while remap enable is set
// [RULE_06] map bits 7..4 govern physical port 2: 0 disabled, 1..4 logical ports
// [RULE_07] map codes 5..15 act as 0, leaving that physical port disabled
// [RULE_08] map bits 3..0 govern physical port 1, value 0 disables it
// [RULE_09] port 1 field codes 1..4 assign logical ports 1..4
// [RULE_10] a second map register gives the same fields for ports 3 and 4
// [RULE_11] software must assign contiguous logical numbers starting at 1
// [RULE_12] hub reports only a port count; the host numbers ports from 1
// [RULE_13] disabled physical ports are left out of the reported port count
module upsr_top (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // register bus
  input wire upsr_pkg::upsr_axi_req_t i_axi,
  output upsr_pkg::upsr_axi_rsp_t o_axi,
  // core PHY side, port 0 upstream, 1..4 downstream
  input wire upsr_pkg::upsr_pair_t i_core_drive,
  input wire logic [4:0] i_core_oe,
  output upsr_pkg::upsr_pair_t o_core_sense,
  // package pins
  input wire upsr_pkg::upsr_pair_t i_pin,
  output upsr_pkg::upsr_pair_t o_pin,
  output upsr_pkg::upsr_pair_t o_pin_oe,
  // remap results toward the hub logic
  output logic [3:0][2:0] o_phys_logical,
  output logic [3:0] o_phys_enabled,
  output logic [2:0] o_port_count
);
  import upsr_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] swap;
    logic [7:0] map12;
    logic [7:0] map34;
    logic remap_en;
    logic aw_held;
    logic [9:0] aw_idx;
    logic w_held;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    upsr_pair_t sync1;
    upsr_pair_t sync2;
    upsr_pair_t pin_out;
    upsr_pair_t pin_oe;
    upsr_pair_t sense;
    logic [3:0][2:0] logical;
    logic [3:0] enabled;
    logic [2:0] count;
  } upsr_state_t;

  upsr_state_t state_ff;
  upsr_state_t nxt_state;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic upsr_sel_t reg_sel(input logic [9:0] idx);
    upsr_sel_t sel;
    sel = UPSR_SEL_NONE;
    if (idx == `UPSR_IDX_CONFIG) begin
      sel = UPSR_SEL_CONFIG;
    end else if (idx == `UPSR_IDX_SWAP) begin
      sel = UPSR_SEL_SWAP;
    end else if (idx == `UPSR_IDX_MAP12) begin
      sel = UPSR_SEL_MAP12;
    end else if (idx == `UPSR_IDX_MAP34) begin
      sel = UPSR_SEL_MAP34;
    end
    return sel;
  endfunction

  // reserved codes fall back to disabled
  function automatic logic [2:0] resolve(input logic [3:0] field);
    logic [2:0] lp;
    lp = 3'h0;
    if (field >= `UPSR_MAP_FIRST && field <= `UPSR_MAP_LAST) begin // RULE_06 RULE_09
      lp = field[2:0];
    end // RULE_07
    return lp;
  endfunction

  // ----------------------------------------
  // pin swap muxing
  // ----------------------------------------
  upsr_pair_t swap_drive;
  upsr_pair_t swap_oe;
  upsr_pair_t swap_sense;
  logic [4:0] swap_bits;

  // bits 7..5 are stored but never reach the muxes
  assign swap_bits = state_ff.swap[4:0]; // RULE_03 RULE_04

  genvar gp;
  generate
    for (gp = 0; gp < UPSR_PORTS; gp++) begin : g_port
      always_comb begin
        if (swap_bits[gp]) begin
          swap_drive.dp[gp] = i_core_drive.dm[gp]; // RULE_02
          swap_drive.dm[gp] = i_core_drive.dp[gp]; // RULE_02
          swap_sense.dp[gp] = state_ff.sync2.dm[gp]; // RULE_02
          swap_sense.dm[gp] = state_ff.sync2.dp[gp]; // RULE_02
        end else begin
          swap_drive.dp[gp] = i_core_drive.dp[gp]; // RULE_01
          swap_drive.dm[gp] = i_core_drive.dm[gp]; // RULE_01
          swap_sense.dp[gp] = state_ff.sync2.dp[gp]; // RULE_01
          swap_sense.dm[gp] = state_ff.sync2.dm[gp]; // RULE_01
        end
        // both pins of a pair share one enable, so swapping needs no oe mux
        swap_oe.dp[gp] = i_core_oe[gp];
        swap_oe.dm[gp] = i_core_oe[gp];
      end
    end
  endgenerate

  // ----------------------------------------
  // remap resolution
  // ----------------------------------------
  logic [3:0][2:0] map_logical;
  logic [3:0] map_enabled;
  logic [2:0] map_count;

  always_comb begin
    map_logical[0] = resolve(state_ff.map12[`UPSR_MAP_LO_MSB:`UPSR_MAP_LO_LSB]); // RULE_08
    map_logical[1] = resolve(state_ff.map12[`UPSR_MAP_HI_MSB:`UPSR_MAP_HI_LSB]); // RULE_06
    map_logical[2] = resolve(state_ff.map34[`UPSR_MAP_LO_MSB:`UPSR_MAP_LO_LSB]); // RULE_10
    map_logical[3] = resolve(state_ff.map34[`UPSR_MAP_HI_MSB:`UPSR_MAP_HI_LSB]); // RULE_10
    if (!state_ff.remap_en) begin
      // identity numbering while remapping is off
      map_logical[0] = 3'h1; // RULE_05
      map_logical[1] = 3'h2; // RULE_05
      map_logical[2] = 3'h3; // RULE_05
      map_logical[3] = 3'h4; // RULE_05
    end
    map_count = 3'h0;
    for (int i = 0; i < UPSR_DOWN; i++) begin
      map_enabled[i] = (map_logical[i] != 3'h0);
      // only a count leaves the hub; duplicate codes are software's problem
      map_count = map_count + {2'h0, map_enabled[i]}; // RULE_12 RULE_13
    end
  end

  // ----------------------------------------
  // bus and register next state
  // ----------------------------------------
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  upsr_sel_t wr_sel;
  upsr_sel_t rd_sel;

  assign aw_take = i_axi.awvalid && !state_ff.aw_held && !state_ff.bvalid;
  assign w_take = i_axi.wvalid && !state_ff.w_held && !state_ff.bvalid;
  assign ar_take = i_axi.arvalid && !state_ff.rvalid;

  always_comb begin
    nxt_state = state_ff;
    wr_sel = reg_sel(state_ff.aw_idx);
    rd_sel = reg_sel(i_axi.araddr[11:2]);
    do_write = state_ff.aw_held && state_ff.w_held && !state_ff.bvalid;

    // address and data may arrive in either order
    if (aw_take) begin
      nxt_state.aw_held = 1'b1;
      nxt_state.aw_idx = i_axi.awaddr[11:2];
    end
    if (w_take) begin
      nxt_state.w_held = 1'b1;
      nxt_state.wbyte = i_axi.wdata[7:0];
      nxt_state.wlane0 = i_axi.wstrb[0];
    end

    if (do_write) begin
      nxt_state.aw_held = 1'b0;
      nxt_state.w_held = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = `UPSR_RESP_OKAY;
      if (wr_sel == UPSR_SEL_NONE) begin
        nxt_state.bresp = `UPSR_RESP_SLVERR;
      end else if (state_ff.wlane0) begin
        case (wr_sel)
          UPSR_SEL_CONFIG: nxt_state.remap_en = state_ff.wbyte[`UPSR_CFG_REMAP_EN_BIT];
          UPSR_SEL_SWAP: nxt_state.swap = state_ff.wbyte;
          UPSR_SEL_MAP12: nxt_state.map12 = state_ff.wbyte;
          UPSR_SEL_MAP34: nxt_state.map34 = state_ff.wbyte;
          default: nxt_state.bresp = `UPSR_RESP_SLVERR;
        endcase
      end
    end else if (state_ff.bvalid && i_axi.bready) begin
      nxt_state.bvalid = 1'b0;
    end

    if (ar_take) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = `UPSR_RESP_OKAY;
      nxt_state.rdata = 32'h0000_0000;
      if (i_axi.araddr[11:2] == `UPSR_IDX_STATUS) begin
        nxt_state.rdata[`UPSR_STAT_COUNT_LSB +: 3] = state_ff.count;
        nxt_state.rdata[`UPSR_STAT_LOGICAL_LSB +: 12] = state_ff.logical;
        nxt_state.rdata[`UPSR_STAT_ENABLED_LSB +: 4] = state_ff.enabled;
      end else if (rd_sel == UPSR_SEL_CONFIG) begin
        nxt_state.rdata[`UPSR_CFG_REMAP_EN_BIT] = state_ff.remap_en;
      end else if (rd_sel == UPSR_SEL_SWAP) begin
        nxt_state.rdata[7:0] = state_ff.swap;
      end else if (rd_sel == UPSR_SEL_MAP12) begin
        nxt_state.rdata[7:0] = state_ff.map12;
      end else if (rd_sel == UPSR_SEL_MAP34) begin
        nxt_state.rdata[7:0] = state_ff.map34;
      end else begin
        nxt_state.rresp = `UPSR_RESP_SLVERR;
      end
    end else if (state_ff.rvalid && i_axi.rready) begin
      nxt_state.rvalid = 1'b0;
    end

    // pin path: two flops before the swap mux reads a pin
    nxt_state.sync1 = i_pin;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.sense = swap_sense;
    nxt_state.pin_out = swap_drive;
    nxt_state.pin_oe = swap_oe;

    nxt_state.logical = map_logical;
    nxt_state.enabled = map_enabled;
    nxt_state.count = map_count;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= '0;
      state_ff.swap <= `UPSR_RST_SWAP;
      state_ff.map12 <= `UPSR_RST_MAP;
      state_ff.map34 <= `UPSR_RST_MAP;
      state_ff.remap_en <= `UPSR_RST_REMAP_EN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    o_axi.awready = !state_ff.aw_held && !state_ff.bvalid;
    o_axi.wready = !state_ff.w_held && !state_ff.bvalid;
    o_axi.bvalid = state_ff.bvalid;
    o_axi.bresp = state_ff.bresp;
    o_axi.arready = !state_ff.rvalid;
    o_axi.rvalid = state_ff.rvalid;
    o_axi.rdata = state_ff.rdata;
    o_axi.rresp = state_ff.rresp;
  end

  assign o_core_sense = state_ff.sense;
  assign o_pin = state_ff.pin_out;
  assign o_pin_oe = state_ff.pin_oe;
  assign o_phys_logical = state_ff.logical;
  assign o_phys_enabled = state_ff.enabled;
  assign o_port_count = state_ff.count;

endmodule

// [logic/upsr_regs.svh]
// register offsets, field positions, reset values and codes for the pin swap
// and port remap block; included by the block's design file
`ifndef UPSR_REGS_SVH
`define UPSR_REGS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define UPSR_IDX_CONFIG 10'h008
`define UPSR_IDX_SWAP 10'h0FA
`define UPSR_IDX_MAP12 10'h0FB
`define UPSR_IDX_MAP34 10'h0FC
`define UPSR_IDX_STATUS 10'h010

// ----------------------------------------
// field positions
// ----------------------------------------
`define UPSR_CFG_REMAP_EN_BIT 0
`define UPSR_SWAP_UP_BIT 0
`define UPSR_MAP_LO_MSB 3
`define UPSR_MAP_LO_LSB 0
`define UPSR_MAP_HI_MSB 7
`define UPSR_MAP_HI_LSB 4
`define UPSR_STAT_COUNT_LSB 0
`define UPSR_STAT_LOGICAL_LSB 8
`define UPSR_STAT_ENABLED_LSB 24

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define UPSR_RST_SWAP 8'h00
`define UPSR_RST_MAP 8'h00
`define UPSR_RST_REMAP_EN 1'b0
`define UPSR_MAP_DISABLED 4'h0
`define UPSR_MAP_FIRST 4'h1
`define UPSR_MAP_LAST 4'h4
`define UPSR_RESP_OKAY 2'h0
`define UPSR_RESP_SLVERR 2'h2

`endif

// [logic/upsr_pkg.sv]
// types shared by the pin swap and port remap block
// assumes a 32-bit AXI4-Lite master with 12-bit byte addresses
package upsr_pkg;

  localparam int UPSR_PORTS = 5;
  localparam int UPSR_DOWN = 4;

  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } upsr_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } upsr_axi_rsp_t;

  // one bit per port: index 0 upstream, 1..4 downstream
  typedef struct packed {
    logic [UPSR_PORTS-1:0] dp;
    logic [UPSR_PORTS-1:0] dm;
  } upsr_pair_t;

  typedef enum logic [4:0] {
    UPSR_SEL_NONE = 5'b00001,
    UPSR_SEL_CONFIG = 5'b00010,
    UPSR_SEL_SWAP = 5'b00100,
    UPSR_SEL_MAP12 = 5'b01000,
    UPSR_SEL_MAP34 = 5'b10000
  } upsr_sel_t;

endpackage

// [verif/upsr_props.sv]
// checker for the pin swap and port remap block
// assumes it is bound into upsr_top and sees only its ports
`timescale 1ns/1ps
module upsr_props (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // bus and pins
  input wire upsr_pkg::upsr_axi_req_t i_axi,
  input wire upsr_pkg::upsr_axi_rsp_t o_axi,
  input wire upsr_pkg::upsr_pair_t i_core_drive,
  input wire logic [4:0] i_core_oe,
  input wire upsr_pkg::upsr_pair_t o_core_sense,
  input wire upsr_pkg::upsr_pair_t i_pin,
  input wire upsr_pkg::upsr_pair_t o_pin,
  input wire upsr_pkg::upsr_pair_t o_pin_oe,
  // remap results
  input wire logic [3:0][2:0] o_phys_logical,
  input wire logic [3:0] o_phys_enabled,
  input wire logic [2:0] o_port_count
);
  import upsr_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sequence s_wr_both;
    i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
  endsequence
  sequence s_rd_take;
    i_axi.arvalid && o_axi.arready;
  endsequence
  // a swap only exchanges the pair, so the xor of the two pins survives it
  a_pin_pair: assert property (i_arst_n [*2] |->
    (o_pin.dp ^ o_pin.dm) == $past(i_core_drive.dp ^ i_core_drive.dm)) else $error("pin pair");
  a_pin_enable: assert property (i_arst_n [*2] |->
    o_pin_oe.dp == $past(i_core_oe) && o_pin_oe.dm == o_pin_oe.dp) else $error("pin enable");
  a_sense_pair: assert property (i_arst_n [*4] |->
    (o_core_sense.dp ^ o_core_sense.dm) == $past(i_pin.dp ^ i_pin.dm, 3)) else $error("sense");
  a_count_ones: assert property (
    o_port_count == $countones(o_phys_enabled)) else $error("port count");
  a_enable_code: assert property (
    o_phys_enabled == {|o_phys_logical[3], |o_phys_logical[2], |o_phys_logical[1],
    |o_phys_logical[0]}) else $error("enable vs code");
  a_code_range: assert property (
    o_phys_logical[0] <= 3'h4 && o_phys_logical[1] <= 3'h4 && o_phys_logical[2] <= 3'h4
    && o_phys_logical[3] <= 3'h4) else $error("logical out of range");
  a_write_turn: assert property (s_wr_both |-> ##2 o_axi.bvalid) else $error("no bvalid");
  a_read_turn: assert property (s_rd_take |=> o_axi.rvalid) else $error("no rvalid");
  a_bresp_hold: assert property (o_axi.bvalid && !i_axi.bready |=>
    o_axi.bvalid && $stable(o_axi.bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (o_axi.rvalid && !i_axi.rready |=>
    o_axi.rvalid && $stable(o_axi.rdata)) else $error("rdata dropped");
endmodule
bind upsr_top upsr_props u_props (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_axi(i_axi),
  .o_axi(o_axi), .i_core_drive(i_core_drive), .i_core_oe(i_core_oe),
  .o_core_sense(o_core_sense), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
  .o_phys_logical(o_phys_logical), .o_phys_enabled(o_phys_enabled),
  .o_port_count(o_port_count));

// [verif/upsr_host_model.sv]
// far-end host model on the package pins
// assumes the wire carries the hub's value where it enables, the host's elsewhere
`timescale 1ns/1ps
module upsr_host_model (
  // clock
  input wire logic i_clock,
  // hub pins
  input wire upsr_pkg::upsr_pair_t i_pin,
  input wire upsr_pkg::upsr_pair_t i_pin_oe,
  output upsr_pkg::upsr_pair_t o_wire
);
  import upsr_pkg::*;
  upsr_pair_t host_ff = '0;
  // new pattern every cycle, so a stale or late sample cannot match by luck
  always @(posedge i_clock) host_ff <= upsr_pair_t'(host_ff * 10'h5 + 10'h3);
  assign o_wire.dp = (i_pin_oe.dp & i_pin.dp) | (~i_pin_oe.dp & host_ff.dp);
  assign o_wire.dm = (i_pin_oe.dm & i_pin.dm) | (~i_pin_oe.dm & host_ff.dm);
endmodule

// [verif/upsr_tb_top.sv]
// self-checking bench for the pin swap and port remap block
// assumes the host model on the pins and an AXI4-Lite master made of tasks
`timescale 1ns/1ps
module upsr_tb_top;
  import upsr_pkg::*;
  logic i_clock = 0;
  logic i_arst_n = 0;
  upsr_axi_req_t ax = '0;
  upsr_axi_rsp_t rs;
  upsr_pair_t drv = '0;
  upsr_pair_t sense, pin, pout, poe, p;
  logic [4:0] oe = '0;
  logic [3:0][2:0] plog;
  logic [3:0] pen;
  logic [2:0] pcnt;
  logic [31:0] d;
  logic [1:0] r;
  logic [3:0] strb = 4'hf;
  int n_errors = 0;
  int checked = 0;
  int sw, m12, m34, en, cnt, st, k;
  int lg[4];
  upsr_top dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_axi(ax), .o_axi(rs),
    .i_core_drive(drv), .i_core_oe(oe), .o_core_sense(sense), .i_pin(pin), .o_pin(pout),
    .o_pin_oe(poe), .o_phys_logical(plog), .o_phys_enabled(pen), .o_port_count(pcnt));
  upsr_host_model host (.i_clock(i_clock), .i_pin(pout), .i_pin_oe(poe), .o_wire(pin));
  initial forever #2 i_clock = ~i_clock;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // readys are judged at the falling edge so the rising edge has no race
  task wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge i_clock);
    ax.awaddr <= a;
    ax.wdata <= v;
    ax.wstrb <= strb;
    ax.awvalid <= 1'h1;
    ax.wvalid <= 1'h1;
    ax.bready <= 1'h1;
    do begin
      @(negedge i_clock);
      ta = ax.awvalid & rs.awready;
      tw = ax.wvalid & rs.wready;
      tb = rs.bvalid;
      r = rs.bresp;
      @(posedge i_clock);
      if (ta) ax.awvalid <= 1'h0;
      if (tw) ax.wvalid <= 1'h0;
    end while (!tb);
    ax.bready <= 1'h0;
  endtask
  task rd(input logic [11:0] a);
    logic ta, tv;
    @(posedge i_clock);
    ax.araddr <= a;
    ax.arvalid <= 1'h1;
    ax.rready <= 1'h1;
    do begin
      @(negedge i_clock);
      ta = ax.arvalid & rs.arready;
      tv = rs.rvalid;
      d = rs.rdata;
      r = rs.rresp;
      @(posedge i_clock);
      if (ta) ax.arvalid <= 1'h0;
    end while (!tv);
    ax.rready <= 1'h0;
  endtask
  task setmap;
    wr(12'h020, en);
    wr(12'h3ec, m12);
    wr(12'h3f0, m34);
    cnt = 0;
    st = 0;
    for (k = 0; k < 4; k++) begin
      lg[k] = ((k < 2 ? m12 : m34) >> (4 * (k % 2))) & 15;
      if (lg[k] > 4) lg[k] = 0;
      if (en == 0) lg[k] = k + 1;
      if (lg[k] != 0) cnt++;
      st = st | (lg[k] << (8 + 3 * k)) | ((lg[k] != 0) << (24 + k));
    end
    @(negedge i_clock);
    for (k = 0; k < 4; k++) chk("logical", plog[k], lg[k]);
    chk("count", pcnt, cnt);
    chk("enabled", pen, (st >> 24) & 15);
    rd(12'h040);
    chk("status", d, st | cnt);
    rd(12'h020);
    chk("config", d, en);
  endtask
  task swaptest;
    sw = $urandom & 255;
    wr(12'h3e8, sw);
    chk("swap write resp", r, 2'h0);
    rd(12'h3e8);
    chk("swap read", d, sw);
    @(posedge i_clock);
    drv <= upsr_pair_t'($urandom);
    oe <= 5'($urandom);
    @(posedge i_clock);
    @(negedge i_clock);
    p = pin;
    for (k = 0; k < 5; k++) begin
      chk("pin dp", pout.dp[k], sw[k] ? drv.dm[k] : drv.dp[k]);
      chk("pin dm", pout.dm[k], sw[k] ? drv.dp[k] : drv.dm[k]);
    end
    chk("pin oe", poe, {oe, oe});
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    for (k = 0; k < 5; k++) begin
      chk("sense dp", sense.dp[k], sw[k] ? p.dm[k] : p.dp[k]);
      chk("sense dm", sense.dm[k], sw[k] ? p.dp[k] : p.dm[k]);
    end
  endtask
  initial begin
    k = $urandom(32'h1fdc);
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'h1;
    rd(12'h3e8);
    chk("swap reset", d, 32'h0000_0000);
    rd(12'h3ec);
    chk("map12 reset", d, 32'h0000_0000);
    rd(12'h3f0);
    chk("map34 reset", d, 32'h0000_0000);
    en = 0;
    m12 = 0;
    m34 = 0;
    setmap;
    $display("test reset done");
    repeat (6) swaptest;
    $display("test swap done");
    en = 1;
    for (int c = 0; c < 16; c++) begin
      m12 = (c << 4) | ((c + 5) & 15);
      m34 = $urandom & 255;
      setmap;
    end
    m12 = 8'h12;
    m34 = 8'h43;
    setmap;
    en = 0;
    setmap;
    $display("test remap done");
    wr(12'h100, 32'h0000_0001);
    chk("bad write resp", r, 2'h2);
    rd(12'h100);
    chk("bad read resp", r, 2'h2);
    chk("bad read data", d, 32'h0000_0000);
    wr(12'h040, 32'h0000_0001);
    chk("status write resp", r, 2'h2);
    // lane 0 strobe low: the write is dropped but still answered okay
    strb = 4'he;
    wr(12'h3e8, 32'h0000_00ff);
    chk("masked write resp", r, 2'h0);
    strb = 4'hf;
    rd(12'h3e8);
    chk("masked write kept", d, sw);
    $display("test bus errors done");
    close_out;
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    close_out;
  end
endmodule
